/* hw/wfpd_detect.sv */
// Wake-up frame control, pattern CRC matching and remote-wake packet detection.
// Assumes a byte stream on pclk from the receive path and an APB master on the same clock.
`timescale 1ns/1ns
`default_nettype none
module wfpd_detect #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [7:0] rx_data,
	input wire logic [47:0] station_addr,
	output logic [3:0] pattern_match,
	output logic remote_wake_match,
	output logic irq
);

	function automatic logic [31:0] wfpd_crc_byte(input logic [31:0] crc, input logic [7:0] data);
		logic [31:0] c;
		c = crc ^ {24'h000000, data};
		for (int b = 0; b < 8; b++) begin
			c = c[0] ? ((c >> 1) ^ wfpd_pkg::CRC_POLY_REFLECTED) : (c >> 1);
		end
		return c;
	endfunction : wfpd_crc_byte

	logic [15:0] ctrl_q;
	logic [15:0] crc_lo_q [wfpd_pkg::NUM_PATTERNS];
	logic [15:0] crc_hi_q [wfpd_pkg::NUM_PATTERNS];
	logic [63:0] mask_q [wfpd_pkg::NUM_PATTERNS];
	logic [4:0] irq_status_q;
	logic [4:0] irq_enable_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic [3:0] pattern_match_q;
	logic remote_wake_match_q;

	logic [3:0] bank;
	logic [3:0] off;
	logic [2:0] pat_sel;
	logic pat_bank;
	logic setup;
	logic wr;
	logic wr_ctrl;
	logic wr_irq_enable;
	logic wr_irq_clear;
	logic hit;
	logic [31:0] rdata;

	assign bank = paddr[9:6];
	assign off = paddr[5:2];
	assign pat_sel = 3'(bank - wfpd_pkg::BANK_PAT0);
	assign pat_bank = (bank >= wfpd_pkg::BANK_PAT0) && (bank < wfpd_pkg::BANK_IRQ);
	assign setup = psel && !penable && !pready_q;
	assign wr = psel && penable && pwrite && pready_q && !pslverr_q;
	assign wr_ctrl = wr && bank == wfpd_pkg::BANK_CTRL && off == wfpd_pkg::OFF_WAKE_FRAME_CONTROL;
	assign wr_irq_enable = wr && bank == wfpd_pkg::BANK_IRQ && off == wfpd_pkg::OFF_IRQ_ENABLE;
	assign wr_irq_clear = wr && bank == wfpd_pkg::BANK_IRQ && off == wfpd_pkg::OFF_IRQ_CLEAR;

	// Address decode and read data; addresses outside the map answer with an error.
	always_comb begin
		hit = 1'b0;
		rdata = 32'h00000000;
		if (paddr[ADDR_W-1:10] == '0 && paddr[1:0] == 2'b00) begin
			if (bank == wfpd_pkg::BANK_CTRL && off == wfpd_pkg::OFF_WAKE_FRAME_CONTROL) begin
				hit = 1'b1;
				rdata = {16'h0000, ctrl_q};
			end else if (pat_bank) begin
				hit = 1'b1;
				unique case (off)
					wfpd_pkg::OFF_CRC_LOW: rdata = {16'h0000, crc_lo_q[pat_sel[1:0]]};
					wfpd_pkg::OFF_CRC_HIGH: rdata = {16'h0000, crc_hi_q[pat_sel[1:0]]};
					wfpd_pkg::OFF_MASK_BYTES_1_16: rdata = {16'h0000, mask_q[pat_sel[1:0]][15:0]};
					wfpd_pkg::OFF_MASK_BYTES_17_32: rdata = {16'h0000, mask_q[pat_sel[1:0]][31:16]};
					wfpd_pkg::OFF_MASK_BYTES_33_48: rdata = {16'h0000, mask_q[pat_sel[1:0]][47:32]};
					wfpd_pkg::OFF_MASK_BYTES_49_64: rdata = {16'h0000, mask_q[pat_sel[1:0]][63:48]};
					default: hit = 1'b0;
				endcase
			end else if (bank == wfpd_pkg::BANK_IRQ) begin
				unique case (off)
					wfpd_pkg::OFF_IRQ_STATUS: begin
						hit = 1'b1;
						rdata = {27'h0000000, irq_status_q};
					end
					wfpd_pkg::OFF_IRQ_ENABLE: begin
						hit = 1'b1;
						rdata = {27'h0000000, irq_enable_q};
					end
					wfpd_pkg::OFF_IRQ_CLEAR: hit = 1'b1;
					default: hit = 1'b0;
				endcase
			end
		end
	end

	// Each transfer completes in its first access cycle; read data is captured in the setup cycle, so it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			if (setup) begin
				pslverr_q <= !hit;
				prdata_q <= pwrite ? 32'h00000000 : rdata;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= wfpd_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[15:0] & wfpd_pkg::CTRL_RW_MASK;
		end
	end

	// All four patterns share one layout, one bank each.
	for (genvar p = 0; p < wfpd_pkg::NUM_PATTERNS; p++) begin : g_pat_regs
		logic sel;
		assign sel = wr && pat_bank && pat_sel[1:0] == 2'(p);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				crc_lo_q[p] <= wfpd_pkg::CRC_REG_RESET;
				crc_hi_q[p] <= wfpd_pkg::CRC_REG_RESET;
				mask_q[p] <= {4{wfpd_pkg::MASK_REG_RESET}};
			end else if (sel) begin
				unique case (off)
					wfpd_pkg::OFF_CRC_LOW: crc_lo_q[p] <= pwdata[15:0];
					wfpd_pkg::OFF_CRC_HIGH: crc_hi_q[p] <= pwdata[15:0];
					wfpd_pkg::OFF_MASK_BYTES_1_16: mask_q[p][15:0] <= pwdata[15:0];
					wfpd_pkg::OFF_MASK_BYTES_17_32: mask_q[p][31:16] <= pwdata[15:0];
					wfpd_pkg::OFF_MASK_BYTES_33_48: mask_q[p][47:32] <= pwdata[15:0];
					wfpd_pkg::OFF_MASK_BYTES_49_64: mask_q[p][63:48] <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// Bytes seen before the first start of frame after reset belong to a cut frame and never report.
	logic in_frame_q;
	logic frame_byte;
	assign frame_byte = rx_valid && (rx_sof || in_frame_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_frame_q <= 1'b0;
		end else if (rx_valid) begin
			in_frame_q <= (rx_sof || in_frame_q) && !rx_eof;
		end
	end

	// Byte position within the frame; saturates once the mask window is passed.
	logic [6:0] byte_idx_q;
	logic [6:0] byte_idx_d;
	logic [6:0] cur_idx;
	assign cur_idx = rx_sof ? 7'h00 : byte_idx_q;

	always_comb begin
		byte_idx_d = byte_idx_q;
		if (rx_valid) begin
			if (cur_idx < 7'(wfpd_pkg::MASK_BYTES)) begin
				byte_idx_d = cur_idx + 7'h01;
			end else begin
				byte_idx_d = cur_idx;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_idx_q <= 7'h00;
		end else begin
			byte_idx_q <= byte_idx_d;
		end
	end

	// Pattern CRC engines. The check is done on the frame's last byte, so a match costs no storage.
	logic [3:0] pat_hit;
	for (genvar p = 0; p < wfpd_pkg::NUM_PATTERNS; p++) begin : g_pat_crc
		logic [31:0] crc_q;
		logic [31:0] crc_in;
		logic [31:0] crc_next;
		logic take;
		assign crc_in = rx_sof ? wfpd_pkg::CRC_INIT : crc_q;
		assign take = cur_idx < 7'(wfpd_pkg::MASK_BYTES) && mask_q[p][cur_idx[5:0]];
		assign crc_next = take ? wfpd_crc_byte(crc_in, rx_data) : crc_in;
		assign pat_hit[p] = frame_byte && rx_eof && ctrl_q[p]
			&& ~crc_next == {crc_hi_q[p], crc_lo_q[p]};
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				crc_q <= wfpd_pkg::CRC_INIT;
			end else if (rx_valid) begin
				crc_q <= crc_next;
			end
		end
	end

	// Remote-wake packet: six sync bytes, then the station address sixteen times in a row.
	logic [2:0] sync_cnt_q;
	logic [2:0] addr_pos_q;
	logic [4:0] rep_cnt_q;
	logic magic_seen_q;
	logic [2:0] sync_cnt_d;
	logic [2:0] addr_pos_d;
	logic [4:0] rep_cnt_d;
	logic magic_seen_d;
	logic [2:0] sync_cur;
	logic [2:0] pos_cur;
	logic [4:0] rep_cur;
	logic seen_cur;
	logic [7:0] addr_byte;
	logic addr_ok;
	logic last_rep;
	logic magic_hit;

	assign sync_cur = rx_sof ? 3'h0 : sync_cnt_q;
	assign pos_cur = rx_sof ? 3'h0 : addr_pos_q;
	assign rep_cur = rx_sof ? 5'h00 : rep_cnt_q;
	assign seen_cur = rx_sof ? 1'b0 : magic_seen_q;
	assign addr_byte = station_addr[8'(47 - 8 * pos_cur) -: 8];
	assign addr_ok = sync_cur == 3'(wfpd_pkg::MAGIC_SYNC_BYTES) && rx_data == addr_byte;
	assign last_rep = addr_ok && pos_cur == 3'(wfpd_pkg::MAGIC_SYNC_BYTES - 1)
		&& rep_cur == 5'(wfpd_pkg::MAGIC_REPEATS - 1);
	assign magic_hit = frame_byte && rx_eof && ctrl_q[wfpd_pkg::CTRL_REMOTE_WAKE_BIT]
		&& (seen_cur || last_rep);

	// Counters move only on valid bytes; a start of frame restarts them from zero.
	always_comb begin
		sync_cnt_d = sync_cnt_q;
		addr_pos_d = addr_pos_q;
		rep_cnt_d = rep_cnt_q;
		magic_seen_d = magic_seen_q;
		if (rx_valid) begin
			magic_seen_d = seen_cur || last_rep;
			if (addr_ok) begin
				sync_cnt_d = sync_cur;
				if (pos_cur == 3'(wfpd_pkg::MAGIC_SYNC_BYTES - 1)) begin
					addr_pos_d = 3'h0;
					rep_cnt_d = last_rep ? 5'h00 : rep_cur + 5'h01;
				end else begin
					addr_pos_d = pos_cur + 3'h1;
					rep_cnt_d = rep_cur;
				end
			end else begin
				addr_pos_d = 3'h0;
				rep_cnt_d = 5'h00;
				if (rx_data != wfpd_pkg::MAGIC_SYNC_VALUE) begin
					sync_cnt_d = 3'h0;
				end else if (sync_cur != 3'(wfpd_pkg::MAGIC_SYNC_BYTES)) begin
					sync_cnt_d = sync_cur + 3'h1;
				end else begin
					sync_cnt_d = sync_cur;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_cnt_q <= 3'h0;
			addr_pos_q <= 3'h0;
			rep_cnt_q <= 5'h00;
			magic_seen_q <= 1'b0;
		end else begin
			sync_cnt_q <= sync_cnt_d;
			addr_pos_q <= addr_pos_d;
			rep_cnt_q <= rep_cnt_d;
			magic_seen_q <= magic_seen_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern_match_q <= 4'h0;
		end else begin
			pattern_match_q <= pat_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_wake_match_q <= 1'b0;
		end else begin
			remote_wake_match_q <= magic_hit;
		end
	end

	// A new event in the same cycle as its clear stays set, so no wake-up is lost.
	logic [4:0] irq_set;
	logic [4:0] irq_clr;
	logic [4:0] irq_status_d;
	logic [4:0] irq_enable_d;
	logic irq_d;
	assign irq_set = {magic_hit, pat_hit};
	assign irq_clr = wr_irq_clear ? pwdata[4:0] : 5'h00;
	assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
	assign irq_enable_d = wr_irq_enable ? pwdata[4:0] : irq_enable_q;
	// The line is built from the next status and enable, so it moves in the same cycle as they do.
	assign irq_d = |(irq_status_d & irq_enable_d);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= wfpd_pkg::IRQ_RESET;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_q <= wfpd_pkg::IRQ_RESET;
		end else begin
			irq_enable_q <= irq_enable_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pattern_match = pattern_match_q;
	assign remote_wake_match = remote_wake_match_q;
	assign irq = irq_q;

endmodule : wfpd_detect
`default_nettype wire

/* hw/wfpd_pkg.sv */
// Constants, register map and field layout for the wake-up frame pattern detector.
// Assumes an APB slave whose register index is bank * 16 + offset; byte address is four times the index.
package wfpd_pkg;
	localparam int NUM_PATTERNS = 4;
	localparam int MASK_BYTES = 64;
	localparam int MAGIC_SYNC_BYTES = 6;
	localparam int MAGIC_REPEATS = 16;
	localparam logic [3:0] BANK_CTRL = 4'h3;
	localparam logic [3:0] BANK_PAT0 = 4'h4;
	localparam logic [3:0] BANK_IRQ = 4'h8;
	localparam logic [3:0] OFF_WAKE_FRAME_CONTROL = 4'ha;
	localparam logic [3:0] OFF_CRC_LOW = 4'h0;
	localparam logic [3:0] OFF_CRC_HIGH = 4'h2;
	localparam logic [3:0] OFF_MASK_BYTES_1_16 = 4'h4;
	localparam logic [3:0] OFF_MASK_BYTES_17_32 = 4'h6;
	localparam logic [3:0] OFF_MASK_BYTES_33_48 = 4'h8;
	localparam logic [3:0] OFF_MASK_BYTES_49_64 = 4'ha;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h0;
	localparam logic [3:0] OFF_IRQ_ENABLE = 4'h2;
	localparam logic [3:0] OFF_IRQ_CLEAR = 4'h4;
	localparam int CTRL_REMOTE_WAKE_BIT = 7;
	localparam logic [15:0] CTRL_RW_MASK = 16'h008f;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CRC_REG_RESET = 16'h0000;
	localparam logic [15:0] MASK_REG_RESET = 16'h0000;
	localparam logic [4:0] IRQ_RESET = 5'h00;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY_REFLECTED = 32'hedb88320;
	localparam logic [7:0] MAGIC_SYNC_VALUE = 8'hff;
endpackage : wfpd_pkg

/* tb/wfpd_checker.sv */
// Port checker for the wake frame pattern detector.
// Assumes one clock domain; bound into every wfpd_detect instance.
`timescale 1ns/1ns
`default_nettype none
module wfpd_checker #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_eof,
	input wire logic [3:0] pattern_match,
	input wire logic remote_wake_match,
	input wire logic irq
);
	logic [7:0] ctrl_q;
	wire logic hit = paddr == ADDR_W'(12'h0e8);
	wire logic irq_cause = pattern_match != 4'h0 || remote_wake_match;
	// Shadow of the control bits, so the enables can be judged without peeking inside.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 8'h00;
		end else if (psel && penable && pready && pwrite && hit) begin
			ctrl_q <= pwdata[7:0] & 8'h8f;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable && !pready;
	endsequence
	AST_READY: assert property (s_setup |=> pready && penable)
		else $error("no ready after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
	AST_CTRL_READ: assert property (pready && !pwrite && hit |-> prdata == {24'h0, ctrl_q})
		else $error("control read wrong");
	AST_PAT_EOF: assert property (pattern_match != 4'h0 |-> $past(rx_valid && rx_eof))
		else $error("match not after last byte");
	AST_PAT_PULSE: assert property (pattern_match != 4'h0 && !(rx_valid && rx_eof) |=> pattern_match == 4'h0)
		else $error("match pulse too long");
	AST_PAT_OFF: assert property ((pattern_match & ~$past(ctrl_q[3:0])) == 4'h0)
		else $error("disabled pattern matched");
	AST_RW_OFF: assert property (remote_wake_match |-> $past(ctrl_q[7]))
		else $error("remote wake while disabled");
	AST_RW_EOF: assert property (remote_wake_match |-> $past(rx_valid && rx_eof))
		else $error("remote wake not after last byte");
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(psel && penable && pwrite && pready) || irq_cause)
		else $error("interrupt without cause");
endmodule : wfpd_checker
bind wfpd_detect wfpd_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* tb/wfpd_rx_src.sv */
// Receive path model: sends one frame per start pulse.
// Assumes start comes only while busy is low.
`timescale 1ns/1ns
`default_nettype none
module wfpd_rx_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic magic,
	input wire logic [7:0] len,
	input wire logic [47:0] station_addr,
	output logic busy,
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_eof,
	output logic [7:0] rx_data
);
	logic [7:0] k_q;
	logic [7:0] n;
	logic [7:0] b;
	always_comb begin
		n = k_q + 8'h01;
		b = n * 8'h25 + 8'h03;
		if (magic) begin
			b = n < 8'h07 ? 8'hff : 8'(station_addr >> (40 - 8 * ((n - 8'h07) % 8'h06)));
		end
	end
	// Idle data toggles so that a stale byte is never mistaken for a valid one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			k_q <= 8'h00;
			busy <= 1'b0;
			rx_valid <= 1'b0;
			rx_sof <= 1'b0;
			rx_eof <= 1'b0;
			rx_data <= 8'h00;
		end else if (start || busy) begin
			busy <= n != len;
			k_q <= n == len ? 8'h00 : n;
			rx_valid <= 1'b1;
			rx_sof <= k_q == 8'h00;
			rx_eof <= n == len;
			rx_data <= b;
		end else begin
			rx_valid <= 1'b0;
			rx_sof <= 1'b0;
			rx_eof <= 1'b0;
			rx_data <= ~rx_data;
		end
	end
endmodule : wfpd_rx_src
`default_nettype wire

/* tb/tb_wake_frame_pattern_detect.sv */
// Self-checking bench for the wake frame pattern detector.
// Assumes the receive model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_wake_frame_pattern_detect;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic start = 1'b0;
	logic magic = 1'b0;
	logic [7:0] len = 8'h00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [47:0] station_addr = 48'h0a1b2c3d4e5f;
	logic [63:0] m = 64'h8000000000018001;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, rx_valid, rx_sof, rx_eof, remote_wake_match, irq, busy, rw_seen;
	logic [7:0] rx_data;
	logic [3:0] pattern_match, pm_seen;
	int mismatches = 0;
	int n_compared = 0;
	wfpd_detect #(.ADDR_W(12)) i_dut (.*);
	wfpd_rx_src i_src (.*);
	initial forever #2 pclk = ~pclk;
	// Match pulses last one cycle, so they are collected here per frame.
	always @(posedge pclk) begin
		pm_seen <= start ? 4'h0 : pm_seen | pattern_match;
		rw_seen <= start ? 1'b0 : rw_seen | remote_wake_match;
	end
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i == 50) begin
			mismatches++;
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, rd, er);
		`CHK(rd, e)
	endtask : rchk
	task automatic send(input logic mg, input logic [7:0] n);
		int i;
		start <= 1'b1;
		magic <= mg;
		len <= n;
		@(posedge pclk);
		start <= 1'b0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while ((busy !== 1'b0 || rx_valid !== 1'b0) && i < 300);
		if (i == 300) begin
			mismatches++;
			test_done();
		end
		repeat (2) @(posedge pclk);
	endtask : send
	function automatic logic [31:0] crc_f(input logic [63:0] mk, input int n);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int k = 1; k <= n; k++) begin
			if (k <= 64 && mk[k - 1]) begin
				c = c ^ {24'h0, 8'(k * 37 + 3)};
				for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
			end
		end
		return ~c;
	endfunction : crc_f
	task automatic t_regs();
		logic [11:0] a;
		for (int i = 0; i < 24; i++) begin
			a = 12'h100 + 12'(i / 6 * 64 + i % 6 * 8);
			rchk(a, 32'h0);
			wr(a, 32'h00005a00 + 32'(i));
		end
		for (int i = 0; i < 24; i++) rchk(12'h100 + 12'(i / 6 * 64 + i % 6 * 8), 32'h00005a00 + 32'(i));
		rchk(12'h0e8, 32'h0);
		wr(12'h0e8, 32'h0000ffff);
		rchk(12'h0e8, 32'h0000008f);
		apb(1'b0, 12'h004, 32'h0, rd, er);
		`CHK(er, 1'b1)
		$display("t_regs done");
	endtask : t_regs
	task automatic t_pat();
		logic [31:0] c;
		c = crc_f(m, 70);
		// Pattern 1 gets a wrong CRC; frame is longer than the mask window.
		for (int p = 0; p < 4; p++) begin
			wr(12'h100 + 12'(p * 64), {16'h0, c[15:0] ^ {15'h0, p == 1}});
			wr(12'h108 + 12'(p * 64), {16'h0, c[31:16]});
			for (int r = 0; r < 4; r++) wr(12'h110 + 12'(p * 64 + r * 8), {16'h0, m[r * 16 +: 16]});
		end
		wr(12'h208, 32'h0);
		wr(12'h0e8, 32'h0000000b);
		send(1'b0, 8'd70);
		`CHK(pm_seen, 4'h9)
		`CHK(irq, 1'b0)
		rchk(12'h200, 32'h00000009);
		wr(12'h208, 32'h0000001f);
		@(posedge pclk);
		`CHK(irq, 1'b1)
		wr(12'h210, 32'h0000001f);
		@(posedge pclk);
		`CHK(irq, 1'b0)
		rchk(12'h200, 32'h0);
		wr(12'h0e8, 32'h00000004);
		send(1'b0, 8'd70);
		`CHK(pm_seen, 4'h4)
		$display("t_pat done");
	endtask : t_pat
	task automatic t_rw();
		wr(12'h0e8, 32'h00000080);
		send(1'b1, 8'd102);
		`CHK(rw_seen, 1'b1)
		`CHK(pm_seen, 4'h0)
		rchk(12'h200, 32'h00000014);
		wr(12'h0e8, 32'h0000000f);
		send(1'b1, 8'd102);
		`CHK(rw_seen, 1'b0)
		$display("t_rw done");
	endtask : t_rw
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pat();
		t_rw();
		test_done();
	end
endmodule : tb_wake_frame_pattern_detect
`default_nettype wire
